// ### common/atc_pkg.sv
package atc_pkg;

   // Register byte addresses on the Wishbone bus (one register per aligned word)
   localparam logic [7:0] SP_HI_OFS    = 8'h00;
   localparam logic [7:0] SP_LO_OFS    = 8'h04;
   localparam logic [7:0] DEV_HI_OFS   = 8'h08;
   localparam logic [7:0] DEV_LO_OFS   = 8'h0C;
   localparam logic [7:0] EVT_STAT_OFS = 8'h10;
   localparam logic [7:0] EVT_CLR_OFS  = 8'h14;
   localparam logic [7:0] EVT_EN_OFS   = 8'h18;
   localparam logic [7:0] CH_BASE      = 8'h20;
   localparam logic [7:0] CH_STRIDE    = 8'h10;
   localparam logic [7:0] CH_CTRL_OFS  = 8'h00;
   localparam logic [7:0] CH_SRC_OFS   = 8'h04;
   localparam logic [7:0] CH_VHI_OFS   = 8'h08;
   localparam logic [7:0] CH_VLO_OFS   = 8'h0C;

   // Channel control field positions
   localparam int CTRL_EN_BIT   = 7;
   localparam int CTRL_POL_BIT  = 4;
   localparam int CTRL_EDGE_BIT = 3;
   localparam int CTRL_MODE_BIT = 0;
   localparam logic [7:0] CTRL_MASK = 8'h99;
   localparam logic [7:0] SRC_MASK  = 8'h07;

   // Widths and reset values
   localparam int PHASE_W  = 10;
   localparam int PERIOD_W = 15;
   localparam int DEV_W    = 16;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] SRC_RST  = 3'h0;
   localparam logic [9:0] VAL_RST  = 10'h000;
   localparam logic [15:0] DEV_RST = 16'h0000;

   // Capture source codes
   localparam logic [2:0] SRC_PIN     = 3'h0;
   localparam logic [2:0] SRC_CMP1    = 3'h1;
   localparam logic [2:0] SRC_CMP2    = 3'h2;
   localparam logic [2:0] SRC_LC1     = 3'h3;
   localparam logic [2:0] SRC_LC2     = 3'h4;
   localparam logic [2:0] SRC_LC3     = 3'h5;
   localparam logic [2:0] SRC_LC4     = 3'h6;
   localparam logic [2:0] SRC_WAVEGEN = 3'h7;

   typedef enum logic [1:0] {
      ATC_BUS_IDLE = 2'b01,
      ATC_BUS_ACK  = 2'b10
   } atc_bus_e;

endpackage

// ### logic/atc_setpoint_capcomp.sv
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// Notes on behaviour
// - Set-point high byte is buffered and applied when the low byte is written.
// - Read-only 16-bit deviation equals measured period minus set point.
// - Control bit 7 enables the channel; at 0 the channel does nothing.
// - Control bit 0 selects capture (1) or compare (0) mode.
// - Capture copies phase count on rising edge, or falling edge when bit 3 set.
// - In capture mode bit 4 makes the update pulse active low.
// - In compare mode output asserts on phase match; bit 4 sets polarity.
// - Three-bit source select picks pin, comparators, logic cells or wave generator.
// - In capture mode the 10-bit channel value is read-only captured phase.
// - In compare mode a phase match raises the channel event and output.
// - Channel value high byte is buffered and transferred on low byte write.
// - Unimplemented bits read as zero.
// - Reset clears control, source and value; set point is not reset.
// - Each capture or compare event sets the channel's sticky event flag.
// - Capture and compare use the live 10-bit phase count.
// - Deviation uses the 15-bit measured period.
module atc_setpoint_capcomp #(
   parameter int NCH = 3
) (
   input  wire logic                          clk,
   input  wire logic                          nrst,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [7:0]                    wb_adr_i,
   input  wire logic [31:0]                   wb_dat_i,
   input  wire logic [3:0]                    wb_sel_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   input  wire logic [atc_pkg::PHASE_W-1:0]   phase_count,
   input  wire logic [atc_pkg::PERIOD_W-1:0]  measured_period,
   input  wire logic                          period_done,
   input  wire logic [NCH-1:0]                channel_pin,
   input  wire logic                          comparator_one_synced,
   input  wire logic                          comparator_two_synced,
   input  wire logic                          logic_cell_one_output,
   input  wire logic                          logic_cell_two_output,
   input  wire logic                          logic_cell_three_output,
   input  wire logic                          logic_cell_four_output,
   input  wire logic                          waveform_gen_irq,
   output logic      [NCH-1:0]                channel_output,
   output logic                               irq
);

   atc_pkg::atc_bus_e                bus_state_reg;
   logic [31:0]                      rd_data_reg;
   logic [31:0]                      rd_mux;
   logic                             wr_stb;
   logic [7:0]                       wr_byte;
   logic [7:0]                       word_adr;
   logic [6:0]                       sp_hi_buf_reg;
   logic [atc_pkg::PERIOD_W-1:0]     set_point_reg;
   logic [atc_pkg::DEV_W-1:0]        deviation_reg;
   logic [NCH-1:0]                   evt_stat_reg;
   logic [NCH-1:0]                   evt_en_reg;
   logic [NCH-1:0]                   evt_set;
   logic [NCH-1:0]                   evt_clr;
   logic [7:0]                       ctrl_reg  [NCH];
   logic [2:0]                       src_reg   [NCH];
   logic [atc_pkg::PHASE_W-1:0]      value_reg [NCH];

   assign word_adr = {wb_adr_i[7:2], 2'b00};
   assign wr_byte  = wb_dat_i[7:0];

   // Write takes effect on the edge where the master sees ack high
   assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
                   (bus_state_reg == atc_pkg::ATC_BUS_ACK);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_state_reg <= atc_pkg::ATC_BUS_IDLE;
      end else begin
         case (bus_state_reg)
            atc_pkg::ATC_BUS_IDLE: begin
               if (wb_cyc_i && wb_stb_i) begin
                  bus_state_reg <= atc_pkg::ATC_BUS_ACK;
               end
            end
            atc_pkg::ATC_BUS_ACK: begin
               bus_state_reg <= atc_pkg::ATC_BUS_IDLE;
            end
            default: begin
               bus_state_reg <= atc_pkg::ATC_BUS_IDLE;
            end
         endcase
      end
   end

   assign wb_ack_o = (bus_state_reg == atc_pkg::ATC_BUS_ACK);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_data_reg <= 32'h00000000;
      end else if (bus_state_reg == atc_pkg::ATC_BUS_IDLE && wb_cyc_i && wb_stb_i) begin
         rd_data_reg <= rd_mux;
      end
   end

   assign wb_dat_o = rd_data_reg;

   // Read mux; unmapped and unimplemented bits return zero
   always_comb begin
      rd_mux = 32'h00000000;
      case (word_adr)
         atc_pkg::SP_HI_OFS:    rd_mux[7:0] = {1'b0, set_point_reg[14:8]};
         atc_pkg::SP_LO_OFS:    rd_mux[7:0] = set_point_reg[7:0];
         atc_pkg::DEV_HI_OFS:   rd_mux[7:0] = deviation_reg[15:8];
         atc_pkg::DEV_LO_OFS:   rd_mux[7:0] = deviation_reg[7:0];
         atc_pkg::EVT_STAT_OFS: rd_mux[NCH-1:0] = evt_stat_reg;
         atc_pkg::EVT_EN_OFS:   rd_mux[NCH-1:0] = evt_en_reg;
         default: begin
            for (int i = 0; i < NCH; i++) begin
               if (word_adr == 8'(atc_pkg::CH_BASE + i * atc_pkg::CH_STRIDE + atc_pkg::CH_CTRL_OFS)) begin
                  rd_mux[7:0] = ctrl_reg[i] & atc_pkg::CTRL_MASK;
               end
               if (word_adr == 8'(atc_pkg::CH_BASE + i * atc_pkg::CH_STRIDE + atc_pkg::CH_SRC_OFS)) begin
                  rd_mux[2:0] = src_reg[i];
               end
               if (word_adr == 8'(atc_pkg::CH_BASE + i * atc_pkg::CH_STRIDE + atc_pkg::CH_VHI_OFS)) begin
                  rd_mux[1:0] = value_reg[i][9:8];
               end
               if (word_adr == 8'(atc_pkg::CH_BASE + i * atc_pkg::CH_STRIDE + atc_pkg::CH_VLO_OFS)) begin
                  rd_mux[7:0] = value_reg[i][7:0];
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sp_hi_buf_reg <= 7'h00;
      end else if (wr_stb && word_adr == atc_pkg::SP_HI_OFS) begin
         sp_hi_buf_reg <= wr_byte[6:0];
      end
   end

   // No reset: the set point must survive warm resets, so it powers up unknown
   always_ff @(posedge clk) begin
      if (wr_stb && word_adr == atc_pkg::SP_LO_OFS) begin
         set_point_reg <= {sp_hi_buf_reg, wr_byte};
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         deviation_reg <= atc_pkg::DEV_RST;
      end else if (period_done) begin
         deviation_reg <= {1'b0, measured_period} - {1'b0, set_point_reg};
      end
   end

   always_comb begin
      evt_clr = '0;
      if (wr_stb && word_adr == atc_pkg::EVT_CLR_OFS) begin
         evt_clr = wr_byte[NCH-1:0];
      end
   end

   // A new event in the clearing cycle wins over the clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         evt_stat_reg <= '0;
      end else begin
         evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         evt_en_reg <= '0;
      end else if (wr_stb && word_adr == atc_pkg::EVT_EN_OFS) begin
         evt_en_reg <= wr_byte[NCH-1:0];
      end
   end

   assign irq = |(evt_stat_reg & evt_en_reg);

   for (genvar g = 0; g < NCH; g++) begin : g_ch
      localparam logic [7:0] BASE = 8'(atc_pkg::CH_BASE + g * atc_pkg::CH_STRIDE);
      logic [2:0] pin_sync_reg;
      logic       pin_level_reg;
      logic       src_prev_reg;
      logic       src_level;
      logic       edge_hit;
      logic       match_prev_reg;
      logic       match;
      logic       enabled;
      logic       capture_mode;
      logic       active_level;
      logic [1:0] val_hi_buf_reg;
      logic       out_reg;

      assign enabled      = ctrl_reg[g][atc_pkg::CTRL_EN_BIT];
      assign capture_mode = ctrl_reg[g][atc_pkg::CTRL_MODE_BIT];

      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            ctrl_reg[g] <= atc_pkg::CTRL_RST;
         end else if (wr_stb && word_adr == BASE + atc_pkg::CH_CTRL_OFS) begin
            ctrl_reg[g] <= wr_byte & atc_pkg::CTRL_MASK;
         end
      end

      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            src_reg[g] <= atc_pkg::SRC_RST;
         end else if (wr_stb && word_adr == BASE + atc_pkg::CH_SRC_OFS) begin
            src_reg[g] <= wr_byte[2:0];
         end
      end

      // Pin is asynchronous; a change counts once stages two and three agree
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            pin_sync_reg  <= 3'h0;
            pin_level_reg <= 1'b0;
         end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], channel_pin[g]};
            if (pin_sync_reg[1] == pin_sync_reg[2]) begin
               pin_level_reg <= pin_sync_reg[2];
            end
         end
      end

      always_comb begin
         case (src_reg[g])
            atc_pkg::SRC_PIN:     src_level = pin_level_reg;
            atc_pkg::SRC_CMP1:    src_level = comparator_one_synced;
            atc_pkg::SRC_CMP2:    src_level = comparator_two_synced;
            atc_pkg::SRC_LC1:     src_level = logic_cell_one_output;
            atc_pkg::SRC_LC2:     src_level = logic_cell_two_output;
            atc_pkg::SRC_LC3:     src_level = logic_cell_three_output;
            atc_pkg::SRC_LC4:     src_level = logic_cell_four_output;
            atc_pkg::SRC_WAVEGEN: src_level = waveform_gen_irq;
            default:              src_level = 1'b0;
         endcase
      end

      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            src_prev_reg   <= 1'b0;
            match_prev_reg <= 1'b0;
         end else begin
            src_prev_reg   <= src_level;
            match_prev_reg <= match;
         end
      end

      assign edge_hit = ctrl_reg[g][atc_pkg::CTRL_EDGE_BIT] ? (src_prev_reg && !src_level)
                                                            : (!src_prev_reg && src_level);
      assign match    = enabled && !capture_mode && (phase_count == value_reg[g]);

      // Compare events fire once on entry to the match, not every cycle of it
      assign evt_set[g] = enabled && (capture_mode ? edge_hit : (match && !match_prev_reg));

      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            val_hi_buf_reg <= 2'h0;
         end else if (wr_stb && word_adr == BASE + atc_pkg::CH_VHI_OFS && !capture_mode) begin
            val_hi_buf_reg <= wr_byte[1:0];
         end
      end

      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            value_reg[g] <= atc_pkg::VAL_RST;
         end else if (enabled && capture_mode && edge_hit) begin
            value_reg[g] <= phase_count;
         end else if (wr_stb && word_adr == BASE + atc_pkg::CH_VLO_OFS && !capture_mode) begin
            value_reg[g] <= {val_hi_buf_reg, wr_byte};
         end
      end

      // Capture gives a one-cycle pulse; compare holds while phase matches
      assign active_level = capture_mode ? evt_set[g] : match;

      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            out_reg <= 1'b0;
         end else begin
            out_reg <= active_level ^ ctrl_reg[g][atc_pkg::CTRL_POL_BIT];
         end
      end

      assign channel_output[g] = out_reg;
   end

endmodule

// ### tb/atc_src_model.sv
`timescale 1ns/100ps
module atc_src_model #(
   parameter int NCH = 3
) (
   input  wire logic [2:0]     src_sel,
   input  wire logic           src_lvl,
   output logic      [NCH-1:0] channel_pin,
   output logic                comparator_one_synced,
   output logic                comparator_two_synced,
   output logic                logic_cell_one_output,
   output logic                logic_cell_two_output,
   output logic                logic_cell_three_output,
   output logic                logic_cell_four_output,
   output logic                waveform_gen_irq
);
   // Only the selected source moves, so a capture from a wrong source shows up as a missing event
   assign channel_pin = {{(NCH-1){1'b0}}, src_lvl && src_sel == atc_pkg::SRC_PIN};
   assign comparator_one_synced = src_lvl && src_sel == atc_pkg::SRC_CMP1;
   assign comparator_two_synced = src_lvl && src_sel == atc_pkg::SRC_CMP2;
   assign logic_cell_one_output = src_lvl && src_sel == atc_pkg::SRC_LC1;
   assign logic_cell_two_output = src_lvl && src_sel == atc_pkg::SRC_LC2;
   assign logic_cell_three_output = src_lvl && src_sel == atc_pkg::SRC_LC3;
   assign logic_cell_four_output = src_lvl && src_sel == atc_pkg::SRC_LC4;
   assign waveform_gen_irq = src_lvl && src_sel == atc_pkg::SRC_WAVEGEN;
endmodule

// ### tb/atc_setpoint_capcomp_monitor.sv
`timescale 1ns/100ps
module atc_setpoint_capcomp_monitor #(
   parameter int NCH = 3
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic [9:0]  phase_count,
   input wire logic [NCH-1:0] channel_output,
   input wire logic        irq
);
   logic [7:0] ctrl_sh;
   logic [7:0] en_sh;
   logic [1:0] vhi_sh;
   logic [9:0] val_sh;
   wire        wr_q = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
   // Shadow of channel 0 and the event enable register; compare value is trusted only while mode stays compare
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_sh <= 8'h00;
         en_sh <= 8'h00;
         vhi_sh <= 2'h0;
         val_sh <= 10'h000;
      end else if (wr_q) begin
         if (wb_adr_i == 8'h20) ctrl_sh <= wb_dat_i[7:0] & 8'h99;
         if (wb_adr_i == 8'h18) en_sh <= wb_dat_i[7:0];
         if (wb_adr_i == 8'h28) vhi_sh <= wb_dat_i[1:0];
         if (wb_adr_i == 8'h2C && !ctrl_sh[0]) val_sh <= {vhi_sh, wb_dat_i[7:0]};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence match_entry;
      ctrl_sh[7] && !ctrl_sh[0] && $stable(ctrl_sh) && $stable(val_sh) && phase_count == val_sh
         && $past(phase_count) != val_sh;
   endsequence
   ack_timing_a: assert property (bus_req |=> wb_ack_o) else $error("ack late");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   rd_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read bits set");
   unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h1C |-> wb_dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   ctrl_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h20 |-> wb_dat_o[7:0] == ctrl_sh)
      else $error("control readback wrong");
   idle_level_a: assert property (!ctrl_sh[7] && $stable(ctrl_sh) |-> channel_output[0] == ctrl_sh[4])
      else $error("disabled output not idle");
   cmp_match_a: assert property (match_entry |=> channel_output[0] != $past(ctrl_sh[4]))
      else $error("compare output missing");
   cap_pulse_a: assert property (ctrl_sh[7] && ctrl_sh[0] && $stable(ctrl_sh) && channel_output[0] != ctrl_sh[4]
      |=> channel_output[0] == $past(ctrl_sh[4])) else $error("capture pulse too long");
   irq_masked_a: assert property (en_sh == 8'h00 |-> !irq) else $error("irq while masked");
endmodule
bind atc_setpoint_capcomp atc_setpoint_capcomp_monitor #(.NCH(NCH)) u_mon (.clk(clk), .nrst(nrst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_count(phase_count),
   .channel_output(channel_output), .irq(irq));

// ### tb/tb_angle_timer_setpoint_capture_compare.sv
`timescale 1ns/100ps
module tb_angle_timer_setpoint_capture_compare;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic [31:0] rd;
   logic        ack;
   logic [9:0]  phase = 10'h000;
   logic [14:0] period = 15'h0000;
   logic        pdone = 1'b0;
   logic        ph_run = 1'b0;
   logic [2:0]  src_sel = 3'h0;
   logic        src_lvl = 1'b0;
   logic [2:0]  pins;
   logic [6:0]  srcs;
   logic [2:0]  outs;
   logic        irq;
   int          err_count = 0;
   int          n_tests = 0;
   always #50 clk = ~clk;
   always @(posedge clk) if (ph_run) phase <= phase + 10'h001;
   atc_src_model #(.NCH(3)) u_src (.src_sel(src_sel), .src_lvl(src_lvl), .channel_pin(pins),
      .comparator_one_synced(srcs[0]), .comparator_two_synced(srcs[1]), .logic_cell_one_output(srcs[2]),
      .logic_cell_two_output(srcs[3]), .logic_cell_three_output(srcs[4]), .logic_cell_four_output(srcs[5]),
      .waveform_gen_irq(srcs[6]));
   atc_setpoint_capcomp #(.NCH(3)) u_dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
      .phase_count(phase), .measured_period(period), .period_done(pdone), .channel_pin(pins),
      .comparator_one_synced(srcs[0]), .comparator_two_synced(srcs[1]), .logic_cell_one_output(srcs[2]),
      .logic_cell_two_output(srcs[3]), .logic_cell_three_output(srcs[4]), .logic_cell_four_output(srcs[5]),
      .waveform_gen_irq(srcs[6]), .channel_output(outs), .irq(irq));
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Wishbone classic master; strobe is tied to cyc so they always move together
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int i;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (ack !== 1'b1 && i < 20);
      if (ack !== 1'b1) begin
         err_count++;
         complete_run();
      end
      rd = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(rd, {24'h000000, e});
   endtask
   task automatic wait_out(input logic l);
      int i;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (outs[0] !== l && i < 1200);
      if (outs[0] !== l) begin
         err_count++;
         complete_run();
      end
   endtask
   task automatic pulse(input logic [14:0] p);
      period <= p;
      pdone <= 1'b1;
      @(posedge clk);
      pdone <= 1'b0;
      @(posedge clk);
   endtask
   task automatic t_reset;
      logic [7:0] ra[8];
      ra = '{8'h08, 8'h0C, 8'h10, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
      foreach (ra[k]) rc(ra[k], 8'h00);
      wb(1'b1, 8'h20, 8'hFF);
      rc(8'h20, atc_pkg::CTRL_MASK);
      wb(1'b1, 8'h24, 8'hFF);
      rc(8'h24, atc_pkg::SRC_MASK);
      wb(1'b1, 8'h20, 8'h00);
   endtask
   task automatic t_setpoint;
      wb(1'b1, atc_pkg::SP_HI_OFS, 8'h01);
      wb(1'b1, atc_pkg::SP_LO_OFS, 8'h00);
      pulse(15'h0150);
      rc(atc_pkg::DEV_LO_OFS, 8'h50);
      wb(1'b1, atc_pkg::SP_HI_OFS, 8'h02);
      pulse(15'h0150);
      rc(atc_pkg::DEV_LO_OFS, 8'h50);
      rc(atc_pkg::SP_HI_OFS, 8'h01);
      wb(1'b1, atc_pkg::SP_LO_OFS, 8'h80);
      rc(atc_pkg::DEV_HI_OFS, 8'h00);
      pulse(15'h0100);
      rc(atc_pkg::DEV_HI_OFS, 8'hFE);
      rc(atc_pkg::DEV_LO_OFS, 8'h80);
      wb(1'b1, atc_pkg::SP_HI_OFS, 8'hFF);
      wb(1'b1, atc_pkg::SP_LO_OFS, 8'h00);
      rc(atc_pkg::SP_HI_OFS, 8'h7F);
      pulse(15'h7FFF);
      rc(atc_pkg::DEV_LO_OFS, 8'hFF);
   endtask
   task automatic t_compare;
      ph_run <= 1'b1;
      wb(1'b1, 8'h20, 8'h80);
      wb(1'b1, 8'h28, 8'h02);
      wb(1'b1, 8'h2C, 8'h34);
      wb(1'b1, 8'h28, 8'h03);
      rc(8'h28, 8'h02);
      wb(1'b1, 8'h2C, 8'h34);
      rc(8'h28, 8'h03);
      wb(1'b1, 8'h18, 8'h01);
      wb(1'b1, 8'h14, 8'h07);
      wait_out(1'b1);
      chk({22'h0, phase}, 32'h00000335);
      @(posedge clk);
      chk({31'h0, outs[0]}, 32'h0);
      rc(8'h10, 8'h01);
      chk({31'h0, irq}, 32'h1);
      wb(1'b1, 8'h14, 8'h01);
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, 8'h20, 8'h90);
      // Output register takes the new polarity one edge after the write lands
      @(posedge clk);
      chk({31'h0, outs[0]}, 32'h1);
      wait_out(1'b0);
      wb(1'b1, 8'h20, 8'h10);
      wb(1'b1, 8'h14, 8'h01);
      repeat (1100) @(posedge clk);
      rc(8'h10, 8'h00);
   endtask
   task automatic t_capture;
      ph_run <= 1'b0;
      // Let the phase counter stop before the bench drives the phase itself
      @(posedge clk);
      for (int s = 0; s < 8; s++) begin
         src_sel <= s[2:0];
         phase <= 10'h100 + s[9:0];
         wb(1'b1, 8'h24, s[7:0]);
         wb(1'b1, 8'h20, 8'h81);
         wb(1'b1, 8'h14, 8'h01);
         src_lvl <= 1'b1;
         wait_out(1'b1);
         rc(8'h28, 8'h01);
         rc(8'h2C, s[7:0]);
         rc(8'h10, 8'h01);
         src_lvl <= 1'b0;
         repeat (6) @(posedge clk);
      end
      wb(1'b1, 8'h2C, 8'hAA);
      rc(8'h2C, 8'h07);
      wb(1'b1, 8'h20, 8'h99);
      wb(1'b1, 8'h14, 8'h01);
      src_lvl <= 1'b1;
      repeat (8) @(posedge clk);
      rc(8'h10, 8'h00);
      phase <= 10'h2C3;
      src_lvl <= 1'b0;
      wait_out(1'b0);
      rc(8'h28, 8'h02);
      rc(8'h2C, 8'hC3);
   endtask
   task automatic t_rereset;
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rc(8'h20, 8'h00);
      rc(8'h2C, 8'h00);
      rc(atc_pkg::SP_HI_OFS, 8'h7F);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset();
      t_setpoint();
      t_compare();
      t_capture();
      t_rereset();
      complete_run();
   end
endmodule
